//--- rtl/avam_defines.vh
`ifndef AVAM_DEFINES_VH
`define AVAM_DEFINES_VH
// ------------------------------------------------
// register byte offsets
// ------------------------------------------------
`define AVAM_OFS_VLAN      6'h00
`define AVAM_OFS_ARP       6'h04
`define AVAM_OFS_SIP_ADDR  6'h08
`define AVAM_OFS_SIP_MASK  6'h0c
`define AVAM_OFS_TIP_ADDR  6'h10
`define AVAM_OFS_TIP_MASK  6'h14
`define AVAM_OFS_HITCNT    6'h18
`define AVAM_OFS_STATUS    6'h1c
// ------------------------------------------------
// vlan register fields
// ------------------------------------------------
`define AVAM_TAG_LSB       0
`define AVAM_VIDEN_BIT     2
`define AVAM_PCPEN_BIT     3
`define AVAM_PCP_LSB       4
`define AVAM_FTYPE_LSB     7
`define AVAM_DENY_BIT      9
`define AVAM_VID_LSB       16
// ------------------------------------------------
// arp register fields
// ------------------------------------------------
`define AVAM_OPCLS_LSB     0
`define AVAM_REQREP_LSB    2
`define AVAM_SIPMD_LSB     4
`define AVAM_TIPMD_LSB     6
`define AVAM_SHA_LSB       8
`define AVAM_THA_LSB       10
`define AVAM_LEN_LSB       12
`define AVAM_HRD_LSB       14
`define AVAM_PRO_LSB       16
// ------------------------------------------------
// reset values
// ------------------------------------------------
`define AVAM_VLAN_RST      32'h0000_0000
`define AVAM_ARP_RST       32'h0002_aa00
`define AVAM_WORD_RST      32'h0000_0000
// ------------------------------------------------
// setting codes
// ------------------------------------------------
`define AVAM_TAG_ANY       2'h0
`define AVAM_TAG_ONLY      2'h1
`define AVAM_UNTAG_ONLY    2'h2
`define AVAM_FT_ANY        2'h0
`define AVAM_FT_ARP        2'h2
`define AVAM_OC_ARP        2'h1
`define AVAM_OC_RARP       2'h2
`define AVAM_OC_OTHER      2'h3
`define AVAM_RR_REQ        2'h1
`define AVAM_RR_REPLY      2'h2
`define AVAM_IP_HOST       2'h1
`define AVAM_IP_NET        2'h2
`define AVAM_CHK_0         2'h0
`define AVAM_CHK_1         2'h1
`define AVAM_CHK_ANY       2'h2
// ------------------------------------------------
// frame field reference values
// ------------------------------------------------
`define AVAM_OP_ARP_REQ    16'h0001
`define AVAM_OP_ARP_REP    16'h0002
`define AVAM_OP_RARP_REQ   16'h0003
`define AVAM_OP_RARP_REP   16'h0004
`define AVAM_HLN_ETH       8'h06
`define AVAM_PLN_IP4       8'h04
`define AVAM_HRD_ETH       16'h0001
`define AVAM_PRO_IP        16'h0800
`define AVAM_VID_NONE      12'h000
`endif

//--- rtl/avam_matcher.v
// Behaviour
// - tag selector any/tagged/untagged, reset any
// - vid filter any or value 1..4095
// - priority filter any or value 0..7
// - arp criteria only when type is arp
// - opcode class any/arp/rarp/unknown
// - request/reply any/request/reply
// - sender ip any/host/network under mask
// - target ip any/host/network under mask
// - arp sha equals/differs source mac
// - rarp tha equals/differs source mac
// - lengths compared with 0x06 and 0x04
// - hrd compared with 1, tri setting
// - pro compared with 0x800, tri setting
// - deny drops hit frame, permit passes
// - hit counter counts every hit
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "avam_defines.vh"

module avam_matcher (
  input  wire        clk,
  input  wire        resetn,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // frame fields from classifier
  input  wire        frm_valid,
  input  wire [1:0]  frm_type,
  input  wire        frm_tagged,
  input  wire [11:0] frm_vid,
  input  wire [2:0]  frm_pcp,
  input  wire [15:0] operation_code_field,
  input  wire [31:0] sender_ip_field,
  input  wire [31:0] frm_target_ip,
  input  wire [47:0] frm_sha,
  input  wire [47:0] frm_tha,
  input  wire [47:0] frame_source_mac,
  input  wire [7:0]  frm_hln,
  input  wire [7:0]  frm_pln,
  input  wire [15:0] hardware_space_field_alias,
  input  wire [15:0] frm_pro,
  // verdict
  output reg         hit,
  output reg         drop,
  output reg         permit
);

  // ------------------------------------------------
  // configuration storage
  // ------------------------------------------------
  reg  [31:0] vlan_ff;      // vlan, type, action
  reg  [31:0] arp_ff;       // arp criteria
  reg  [31:0] sip_addr_ff;  // sender ip address
  reg  [31:0] sip_mask_ff;  // sender ip mask
  reg  [31:0] tip_addr_ff;  // target ip address
  reg  [31:0] tip_mask_ff;  // target ip mask
  reg  [31:0] hitcnt_ff;    // hit counter
  reg  [1:0]  last_ff;      // last verdict flags
  reg  [31:0] nxt_rd;       // read mux
  wire [31:0] bmask;        // byte lane mask
  wire        wb_req;       // new request
  wire        wb_wr;        // write this edge

  // ------------------------------------------------
  // field extraction
  // ------------------------------------------------
  wire [1:0]  tag_sel = vlan_ff[`AVAM_TAG_LSB +: 2];
  wire        vid_en  = vlan_ff[`AVAM_VIDEN_BIT];
  wire        pcp_en  = vlan_ff[`AVAM_PCPEN_BIT];
  wire [2:0]  pcp_val = vlan_ff[`AVAM_PCP_LSB +: 3];
  wire [1:0]  ftype   = vlan_ff[`AVAM_FTYPE_LSB +: 2];
  wire        deny    = vlan_ff[`AVAM_DENY_BIT];
  wire [11:0] vid_val = vlan_ff[`AVAM_VID_LSB +: 12];
  wire [1:0]  opcls   = arp_ff[`AVAM_OPCLS_LSB +: 2];
  wire [1:0]  reqrep  = arp_ff[`AVAM_REQREP_LSB +: 2];
  wire [1:0]  sip_md  = arp_ff[`AVAM_SIPMD_LSB +: 2];
  wire [1:0]  tip_md  = arp_ff[`AVAM_TIPMD_LSB +: 2];
  wire [1:0]  sha_chk = arp_ff[`AVAM_SHA_LSB +: 2];
  wire [1:0]  tha_chk = arp_ff[`AVAM_THA_LSB +: 2];
  wire [1:0]  len_chk = arp_ff[`AVAM_LEN_LSB +: 2];
  wire [1:0]  hrd_chk = arp_ff[`AVAM_HRD_LSB +: 2];
  wire [1:0]  pro_chk = arp_ff[`AVAM_PRO_LSB +: 2];

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  // tri setting: 1 needs cond, 0 needs not cond
  function chk3;
    input [1:0] set;
    input       cond;
    begin
      case (set)
        `AVAM_CHK_0: chk3 = ~cond;
        `AVAM_CHK_1: chk3 = cond;
        default:     chk3 = 1'b1;
      endcase
    end
  endfunction

  // ip filter: any, host or masked network
  function ipm;
    input [1:0]  md;
    input [31:0] fld;
    input [31:0] adr;
    input [31:0] msk;
    begin
      case (md)
        `AVAM_IP_HOST: ipm = (fld == adr);
        `AVAM_IP_NET:  ipm = ((fld & msk) == (adr & msk));
        default:       ipm = 1'b1;
      endcase
    end
  endfunction

  // ------------------------------------------------
  // vlan criteria
  // ------------------------------------------------
  // tag selector, any by default
  wire m_tag = (tag_sel == `AVAM_TAG_ANY) |
               ((tag_sel == `AVAM_TAG_ONLY) & frm_tagged) |
               ((tag_sel == `AVAM_UNTAG_ONLY) & ~frm_tagged);
  // vid zero is illegal and never hits
  wire m_vid = ~vid_en | (frm_tagged &
               (vid_val != `AVAM_VID_NONE) & (frm_vid == vid_val));
  // priority only exists on tagged frames
  wire m_pcp = ~pcp_en | (frm_tagged & (frm_pcp == pcp_val));
  // frame type of the entry
  wire m_type = (ftype == `AVAM_FT_ANY) | (ftype == frm_type);

  // ------------------------------------------------
  // arp criteria
  // ------------------------------------------------
  wire op_areq = (operation_code_field == `AVAM_OP_ARP_REQ);
  wire op_arep = (operation_code_field == `AVAM_OP_ARP_REP);
  wire op_rreq = (operation_code_field == `AVAM_OP_RARP_REQ);
  wire op_rrep = (operation_code_field == `AVAM_OP_RARP_REP);
  wire is_arp  = op_areq | op_arep;
  wire is_rarp = op_rreq | op_rrep;
  reg  m_cls;  // opcode class
  reg  m_rr;   // request or reply

  // opcode class selection
  always @* begin
    case (opcls)
      `AVAM_OC_ARP:   m_cls = is_arp;
      `AVAM_OC_RARP:  m_cls = is_rarp;
      `AVAM_OC_OTHER: m_cls = ~is_arp & ~is_rarp;
      default:        m_cls = 1'b1;
    endcase
  end

  // request or reply selection
  always @* begin
    case (reqrep)
      `AVAM_RR_REQ:   m_rr = op_areq | op_rreq;
      `AVAM_RR_REPLY: m_rr = op_arep | op_rrep;
      default:        m_rr = 1'b1;
    endcase
  end

  // sender and target ip
  wire m_sip = ipm(sip_md, sender_ip_field,
                   sip_addr_ff, sip_mask_ff);
  wire m_tip = ipm(tip_md, frm_target_ip,
                   tip_addr_ff, tip_mask_ff);
  // hardware address checks, own opcode kind only
  wire m_sha = (sha_chk == `AVAM_CHK_ANY) |
               (is_arp & chk3(sha_chk, frm_sha == frame_source_mac));
  wire m_tha = (tha_chk == `AVAM_CHK_ANY) |
               (is_rarp & chk3(tha_chk, frm_tha == frame_source_mac));
  // length, hardware and protocol space
  wire m_len = chk3(len_chk, (frm_hln == `AVAM_HLN_ETH) &
                             (frm_pln == `AVAM_PLN_IP4));
  wire m_hrd = chk3(hrd_chk,
                    hardware_space_field_alias == `AVAM_HRD_ETH);
  wire m_pro = chk3(pro_chk, frm_pro == `AVAM_PRO_IP);

  // arp terms count only on an arp entry
  wire arp_all = m_cls & m_rr & m_sip & m_tip & m_sha &
                 m_tha & m_len & m_hrd & m_pro;
  wire m_arp   = (ftype != `AVAM_FT_ARP) | arp_all;

  // full conjunction of criteria
  wire match = m_tag & m_vid & m_pcp & m_type & m_arp;
  wire nxt_hit = frm_valid & match;

  // ------------------------------------------------
  // verdict outputs
  // ------------------------------------------------
  // one cycle pulses after the frame strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hit    <= 1'b0;
      drop   <= 1'b0;
      permit <= 1'b0;
    end else begin
      hit    <= nxt_hit;
      drop   <= nxt_hit & deny;
      permit <= nxt_hit & ~deny;
    end
  end

  // ------------------------------------------------
  // wishbone decode
  // ------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;
  assign bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // read mux, unmapped reads zero
  always @* begin
    case (wb_adr_i)
      `AVAM_OFS_VLAN:     nxt_rd = vlan_ff;
      `AVAM_OFS_ARP:      nxt_rd = arp_ff;
      `AVAM_OFS_SIP_ADDR: nxt_rd = sip_addr_ff;
      `AVAM_OFS_SIP_MASK: nxt_rd = sip_mask_ff;
      `AVAM_OFS_TIP_ADDR: nxt_rd = tip_addr_ff;
      `AVAM_OFS_TIP_MASK: nxt_rd = tip_mask_ff;
      `AVAM_OFS_HITCNT:   nxt_rd = hitcnt_ff;
      `AVAM_OFS_STATUS:   nxt_rd = {30'h0000_0000, last_ff};
      default:            nxt_rd = 32'h0000_0000;
    endcase
  end

  // ack one cycle after request, then drop
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `AVAM_WORD_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req & ~wb_we_i) begin
        wb_dat_o <= nxt_rd;
      end
    end
  end

  // ------------------------------------------------
  // configuration writes
  // ------------------------------------------------
  // byte lanes merge into stored words
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vlan_ff     <= `AVAM_VLAN_RST;
      arp_ff      <= `AVAM_ARP_RST;
      sip_addr_ff <= `AVAM_WORD_RST;
      sip_mask_ff <= `AVAM_WORD_RST;
      tip_addr_ff <= `AVAM_WORD_RST;
      tip_mask_ff <= `AVAM_WORD_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `AVAM_OFS_VLAN: begin
          vlan_ff <= (vlan_ff & ~bmask) | (wb_dat_i & bmask);
        end
        `AVAM_OFS_ARP: begin
          arp_ff <= (arp_ff & ~bmask) | (wb_dat_i & bmask);
        end
        `AVAM_OFS_SIP_ADDR: begin
          sip_addr_ff <= (sip_addr_ff & ~bmask) | (wb_dat_i & bmask);
        end
        `AVAM_OFS_SIP_MASK: begin
          sip_mask_ff <= (sip_mask_ff & ~bmask) | (wb_dat_i & bmask);
        end
        `AVAM_OFS_TIP_ADDR: begin
          tip_addr_ff <= (tip_addr_ff & ~bmask) | (wb_dat_i & bmask);
        end
        `AVAM_OFS_TIP_MASK: begin
          tip_mask_ff <= (tip_mask_ff & ~bmask) | (wb_dat_i & bmask);
        end
        default: begin
          vlan_ff <= vlan_ff;  // hit counter, read only status or unmapped
        end
      endcase
    end
  end

  // ------------------------------------------------
  // hit counter and status
  // ------------------------------------------------
  // write clears, a hit in the same cycle loads the count as one
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hitcnt_ff <= `AVAM_WORD_RST;
      last_ff   <= 2'h0;
    end else begin
      if (wb_wr & (wb_adr_i == `AVAM_OFS_HITCNT)) begin
        hitcnt_ff <= {31'h0000_0000, nxt_hit};
      end else if (nxt_hit) begin
        hitcnt_ff <= hitcnt_ff + 32'h0000_0001;
      end
      if (frm_valid) begin
        last_ff <= {nxt_hit & deny, nxt_hit};
      end
    end
  end

endmodule // avam_matcher
`default_nettype wire

//--- dv/avam_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------
// port checker for the entry matcher
// ----------------------------------
module avam_chk (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        frm_valid,
  input wire logic [1:0]  frm_type,
  input wire logic        frm_tagged,
  input wire logic [11:0] frm_vid,
  input wire logic [2:0]  frm_pcp,
  input wire logic [15:0] operation_code_field,
  input wire logic        hit,
  input wire logic        drop,
  input wire logic        permit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [31:0] vlan_ff; // shadow of the vlan word
  logic [31:0] arp_ff;  // shadow of the arp word
  logic        wr;      // write taken at this edge
  logic        arp_op;  // opcode is an arp request or reply
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign arp_op = operation_code_field == 16'h0001 || operation_code_field == 16'h0002;
  // shadows follow full-word writes, so config tracks what frames see
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) vlan_ff <= 32'h0000_0000;
    else if (wr && wb_adr_i == 6'h00) vlan_ff <= wb_dat_i;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) arp_ff <= 32'h0002_aa00;
    else if (wr && wb_adr_i == 6'h04) arp_ff <= wb_dat_i;
  hit_cause_a: assert property (hit |-> $past(frm_valid))
    else $error("hit with no frame taken");
  verdict_pair_a: assert property (hit == (drop ^ permit) && !(drop && permit))
    else $error("verdict does not follow hit");
  deny_drop_a: assert property (frm_valid && vlan_ff[9] |=> !permit)
    else $error("deny entry let a frame pass");
  tag_only_a: assert property (frm_valid && vlan_ff[1:0] == 2'h1 && !frm_tagged |=> !hit)
    else $error("untagged frame hit a tagged-only entry");
  untag_only_a: assert property (frm_valid && vlan_ff[1:0] == 2'h2 && frm_tagged |=> !hit)
    else $error("tagged frame hit an untagged-only entry");
  vid_filter_a: assert property (frm_valid && vlan_ff[2] && frm_vid != vlan_ff[27:16] |=> !hit)
    else $error("wrong vlan id hit");
  pcp_filter_a: assert property (frm_valid && vlan_ff[3] && frm_pcp != vlan_ff[6:4] |=> !hit)
    else $error("wrong tag priority hit");
  frame_type_a: assert property (frm_valid && vlan_ff[8:7] != 2'h0 && frm_type != vlan_ff[8:7]
    |=> !hit) else $error("wrong frame type hit");
  opcode_arp_a: assert property (frm_valid && vlan_ff[8:7] == 2'h2 && arp_ff[1:0] == 2'h1
    && !arp_op |=> !hit) else $error("non-arp opcode hit");
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a one-cycle answer");
endmodule // avam_chk
bind avam_matcher avam_chk u_chk (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .frm_valid(frm_valid), .frm_type(frm_type), .frm_tagged(frm_tagged),
  .frm_vid(frm_vid), .frm_pcp(frm_pcp), .operation_code_field(operation_code_field),
  .hit(hit), .drop(drop), .permit(permit));
`default_nettype wire

//--- dv/avam_src.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------
// ingress classifier model
// ----------------------------------
module avam_src (
  input  wire logic         go,   // frame strobe from bench
  input  wire logic [289:0] fr,   // packed frame fields
  output logic              frm_valid,
  output logic [1:0]        frm_type,
  output logic              frm_tagged,
  output logic [11:0]       frm_vid,
  output logic [2:0]        frm_pcp,
  output logic [15:0]       operation_code_field,
  output logic [31:0]       sender_ip_field,
  output logic [31:0]       frm_target_ip,
  output logic [47:0]       frm_sha,
  output logic [47:0]       frm_tha,
  output logic [47:0]       frame_source_mac,
  output logic [7:0]        frm_hln,
  output logic [7:0]        frm_pln,
  output logic [15:0]       hardware_space_field_alias,
  output logic [15:0]       frm_pro
);
  // idle fields show the inverse, so a stale value never passes as live
  assign frm_valid = go;
  assign {frm_type, frm_tagged, frm_vid, frm_pcp, operation_code_field, sender_ip_field,
    frm_target_ip, frm_sha, frm_tha, frame_source_mac, frm_hln, frm_pln,
    hardware_space_field_alias, frm_pro} = go ? fr : ~fr;
endmodule // avam_src
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0, resetn = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [5:0] wb_adr = 6'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o, rd, rs = 32'ha8064ccb;
  logic wb_ack_o, hit, drop, permit, go_q = 1'b0, go_n, tg; // outputs, strobe
  logic [289:0] fr_q = '0;                                  // packed frame to model
  logic [31:0] cfg [6];                                     // entry words
  logic [1:0] ft, lst = 2'h0;                               // frame kind, expected status
  logic [11:0] vid;
  logic [2:0] pcp;
  logic [15:0] code, hsp, psp;
  logic [31:0] snd_ip, tgt_ip;
  logic [47:0] sha, tha, src_mac;
  logic [7:0] hln, pln;
  int bad_count = 0, n_compared = 0, hits = 0, ncyc = 0;
  logic frm_valid, frm_tagged;
  logic [1:0] frm_type;
  logic [11:0] frm_vid;
  logic [2:0] frm_pcp;
  logic [15:0] operation_code_field, hardware_space_field_alias, frm_pro;
  logic [31:0] sender_ip_field, frm_target_ip;
  logic [47:0] frm_sha, frm_tha, frame_source_mac;
  logic [7:0] frm_hln, frm_pln;
  avam_matcher dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frm_valid(frm_valid), .frm_type(frm_type),
    .frm_tagged(frm_tagged), .frm_vid(frm_vid), .frm_pcp(frm_pcp),
    .operation_code_field(operation_code_field), .sender_ip_field(sender_ip_field),
    .frm_target_ip(frm_target_ip), .frm_sha(frm_sha), .frm_tha(frm_tha),
    .frame_source_mac(frame_source_mac), .frm_hln(frm_hln), .frm_pln(frm_pln),
    .hardware_space_field_alias(hardware_space_field_alias), .frm_pro(frm_pro),
    .hit(hit), .drop(drop), .permit(permit));
  avam_src src (.go(go_q), .fr(fr_q), .frm_valid(frm_valid), .frm_type(frm_type),
    .frm_tagged(frm_tagged), .frm_vid(frm_vid), .frm_pcp(frm_pcp),
    .operation_code_field(operation_code_field), .sender_ip_field(sender_ip_field),
    .frm_target_ip(frm_target_ip), .frm_sha(frm_sha), .frm_tha(frm_tha),
    .frame_source_mac(frame_source_mac), .frm_hln(frm_hln), .frm_pln(frm_pln),
    .hardware_space_field_alias(hardware_space_field_alias), .frm_pro(frm_pro));
  always #4 clk = ~clk;
  function automatic logic [31:0] rnd(); // lfsr step
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs;
  endfunction
  function automatic logic tri_ok(input logic [1:0] s, input logic c); // 2 and 3 are any
    return s[1] || c == s[0];
  endfunction
  function automatic logic ip_ok(input logic [1:0] m, input logic [31:0] f, k, mk);
    return m == 2'h1 ? f == k : m == 2'h2 ? (f & mk) == (k & mk) : 1'b1;
  endfunction
  function automatic logic exp_hit(); // all criteria must hold
    logic [31:0] v, a;
    logic ao, ro;
    v = cfg[0];
    a = cfg[1];
    ao = code == 16'h0001 || code == 16'h0002;
    ro = code == 16'h0003 || code == 16'h0004;
    exp_hit = (v[1:0] != 2'h1 || tg) && (v[1:0] != 2'h2 || !tg)
      && (!v[2] || tg && v[27:16] != 12'h000 && vid == v[27:16])
      && (!v[3] || tg && pcp == v[6:4]) && (v[8:7] == 2'h0 || ft == v[8:7]);
    if (v[8:7] == 2'h2)
      exp_hit &= (a[1:0] == 2'h0 || a[1:0] == 2'h1 && ao || a[1:0] == 2'h2 && ro
        || a[1:0] == 2'h3 && !ao && !ro) && (a[3:2] == 2'h0
        || a[3:2] == 2'h1 && code[0] && (ao || ro) || a[3:2] == 2'h2 && !code[0] && (ao || ro))
        && ip_ok(a[5:4], snd_ip, cfg[2], cfg[3]) && ip_ok(a[7:6], tgt_ip, cfg[4], cfg[5])
        && (a[9:8] == 2'h2 || ao && (a[9] || (sha == src_mac) == a[8]))
        && (a[11:10] == 2'h2 || ro && (a[11] || (tha == src_mac) == a[10]))
        && tri_ok(a[13:12], hln == 8'h06 && pln == 8'h04)
        && tri_ok(a[15:14], hsp == 16'h0001) && tri_ok(a[17:16], psp == 16'h0800);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic new_frame(); // fields lean towards the entry so hits occur
    logic [31:0] r, q;
    r = rnd();
    q = rnd();
    tg = r[0];
    vid = r[1] ? cfg[0][27:16] : q[11:0];
    pcp = r[2] ? cfg[0][6:4] : q[14:12];
    ft = r[3] ? cfg[0][8:7] : q[16:15];
    code = {13'h0000, q[19:17]};
    snd_ip = r[4] ? cfg[2] : rnd();
    tgt_ip = r[5] ? cfg[4] : rnd();
    src_mac = {q[15:0], r};
    sha = r[6] ? src_mac : ~src_mac;
    tha = r[7] ? src_mac : ~src_mac;
    hln = r[8] ? 8'h06 : q[27:20];
    pln = r[9] ? 8'h04 : q[7:0];
    hsp = r[10] ? 16'h0001 : q[31:16];
    psp = r[11] ? 16'h0800 : q[15:0];
    go_n = r[12] || r[13];
  endtask
  task automatic run(input int n); // load entry, stream frames, check counter
    logic pe, e;
    pe = 1'b0;
    for (int i = 0; i < 6; i++) wb(1'b1, 6'(4 * i), cfg[i], rd);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 6'(4 * i), 32'h0000_0000, rd);
      chk("entry word", rd, cfg[i]);
    end
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      new_frame();
      if (i == n) go_n = 1'b0;
      e = go_n && exp_hit();
      if (go_n) lst = {e && cfg[0][9], e};
      go_q <= go_n;
      fr_q <= {ft, tg, vid, pcp, code, snd_ip, tgt_ip, sha, tha, src_mac, hln, pln, hsp, psp};
      #1;
      chk("hit", hit, pe);
      chk("drop", drop, pe && cfg[0][9]);
      chk("permit", permit, pe && !cfg[0][9]);
      hits += pe;
      pe = e;
    end
    wb(1'b0, 6'h18, 32'h0000_0000, rd);
    chk("hit counter", rd, hits);
    wb(1'b0, 6'h1c, 32'h0000_0000, rd);
    chk("status", rd, {30'h0000_0000, lst});
    $display("test run of %0d frames done", n);
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin // hang guard
    ncyc++;
    if (ncyc == 12000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    wb(1'b0, 6'h04, 32'h0000_0000, rd);
    chk("arp reset", rd, 32'h0002_aa00);
    wb(1'b0, 6'h00, 32'h0000_0000, rd);
    chk("vlan reset", rd, 32'h0000_0000);
    wb(1'b1, 6'h20, 32'hffff_ffff, rd);
    wb(1'b0, 6'h20, 32'h0000_0000, rd);
    chk("unmapped", rd, 32'h0000_0000);
    wb_sel <= 4'h5;
    wb(1'b1, 6'h08, 32'h1234_5678, rd);
    wb_sel <= 4'hf;
    wb(1'b0, 6'h08, 32'h0000_0000, rd);
    chk("byte lanes", rd, 32'h0034_0078);
    foreach (cfg[i]) cfg[i] = 32'h0000_0000;
    cfg[1] = 32'h0002_aa00;
    run(20); // reset entry: every frame hits
    cfg[0] = 32'h0fff_0005;
    run(60); // tagged only, vid 4095
    for (int k = 0; k < 4; k++) begin // every opcode class and reply kind
      cfg[0] = 32'h0000_0100;
      cfg[1] = 32'h0002_aa00 | k | ((k % 3) << 2);
      run(60);
    end
    repeat (30) begin
      foreach (cfg[i]) cfg[i] = rnd();
      cfg[0] &= 32'h0fff_03ff;
      cfg[1] &= 32'h0003_ffff;
      if (cfg[0][1:0] == 2'h3) cfg[0][1:0] = 2'h0;
      if (cfg[1][3:2] == 2'h3) cfg[1][3:2] = 2'h0;
      if (cfg[0][7]) cfg[0][8:7] = 2'h2;
      run(60);
    end
    wb(1'b1, 6'h18, 32'h0000_0000, rd);
    wb(1'b0, 6'h18, 32'h0000_0000, rd);
    chk("cleared counter", rd, 32'h0000_0000);
    end_sim();
  end
endmodule // tb
`default_nettype wire
